// ### dv/link_cfg_monitor.sv
`timescale 1ns/1ps
module link_cfg_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // Inputs watched
  input wire logic        link_enable,
  input wire logic        mode_is_64b66b,
  input wire logic [2:0]  mode_e,
  input wire logic [4:0]  mode_f,
  // Outputs watched
  input wire logic        link_reset,
  input wire logic        serializer_clock_en,
  input wire logic [7:0]  lane_power_a,
  input wire logic [7:0]  lane_power_b,
  input wire logic        scramble_active,
  input wire logic [4:0]  test_pattern_select,
  input wire logic        serial_hold_low,
  input wire logic        serial_hold_high,
  input wire logic [11:0] frames_per_multiframe_minus_one,
  input wire logic [11:0] multiframe_count,
  input wire logic        multiframe_boundary
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Length taken from the mode; F of zero is left out of the check
  wire [11:0] k66 = ({9'h000, mode_e} * 12'h100) / {7'h00, mode_f} - 12'h001;

  lane_map_a: assert property (
    lane_power_a == lane_power_b && (lane_power_a == 8'h00 || lane_power_a == 8'h0F ||
    lane_power_a == 8'hF0)) else $error("lane power pattern illegal");
  lanes_off_a: assert property (
    !link_enable |=> lane_power_a == 8'h00 && lane_power_b == 8'h00)
    else $error("lanes powered while link off");
  link_on_a: assert property (
    link_enable |=> !link_reset && serializer_clock_en) else $error("link held while enabled");
  count_off_a: assert property (
    !link_enable |=> multiframe_count == 12'h000 && !multiframe_boundary)
    else $error("multiframe counter runs while link off");
  scr_always_a: assert property (
    link_enable && mode_is_64b66b |=> scramble_active) else $error("64b66b not scrambled");
  scr_off_a: assert property (
    !link_enable |=> !scramble_active) else $error("scrambler on while link off");
  hold_low_a: assert property (
    serial_hold_low |-> test_pattern_select == 5'h0A && !serial_hold_high)
    else $error("hold low without its code");
  hold_high_a: assert property (
    $past(link_enable) && test_pattern_select == 5'h0B |-> serial_hold_high)
    else $error("hold high missing");
  k_mode_a: assert property (
    mode_is_64b66b && mode_f != 5'h00 |=> frames_per_multiframe_minus_one == $past(k66))
    else $error("64b66b length not from mode");

  // Main scenarios reached
  wrap_c: cover property (multiframe_boundary);
  upper_c: cover property (lane_power_a == 8'hF0);
  high_c: cover property (serial_hold_high);
endmodule

// ### dv/link_rx_model.sv
`timescale 1ns/1ps
module link_rx_model (
  // Clock
  input wire logic clock,
  // Requests from the bench
  input wire logic want_sync,
  input wire logic want_stamp,
  // Pins, active low
  output logic     sync_input_pin,
  output logic     timestamp_input_pin
);
  // Idle high until the receiver asks for alignment
  initial begin
    sync_input_pin = 1'b1;
    timestamp_input_pin = 1'b1;
  end
  // Pins move only after a clock edge, like real receiver logic
  always @(posedge clock) begin
    sync_input_pin <= !want_sync;
    timestamp_input_pin <= !want_stamp;
  end
endmodule

// ### dv/tb_serial_link_config_regs.sv
`timescale 1ns/1ps
module tb_serial_link_config_regs import link_cfg_pkg::*; ;
  logic        clock, sys_rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo_o, spi_sdo_oe;
  logic        link_enable, timestamp_receiver_enable, mode_is_64b66b, frame_tick;
  logic        want_sync, want_stamp, sync_input_pin, timestamp_input_pin;
  logic [2:0]  mode_e;
  logic [4:0]  mode_f, test_pattern_select;
  logic        link_reset, serializer_clock_en, sync_request_n, sample_twos_complement;
  logic        scramble_active, serial_hold_low, serial_hold_high, multiframe_boundary;
  logic [7:0]  lane_power_a, lane_power_b, rdv;
  logic [11:0] frames_per_multiframe_minus_one, multiframe_count;
  logic [7:0]  mdl [4];
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          kk, cnt;
  logic        pin;
  test_pat_t   codes [10] = '{PAT_NORMAL, PAT_PRBS7, PAT_PRBS15, PAT_PRBS23, PAT_RAMP,
    PAT_TRANSPORT, PAT_HOLD_LOW, PAT_HOLD_HIGH, PAT_PRBS9, PAT_PRBS31};

  serial_link_config_regs dut_u (.clock, .sys_rst, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo_o,
    .spi_sdo_oe, .link_enable, .timestamp_receiver_enable, .mode_is_64b66b, .mode_e, .mode_f,
    .sync_input_pin, .timestamp_input_pin, .frame_tick, .link_reset, .serializer_clock_en,
    .lane_power_a, .lane_power_b, .sync_request_n, .sample_twos_complement, .scramble_active,
    .test_pattern_select, .serial_hold_low, .serial_hold_high, .frames_per_multiframe_minus_one,
    .multiframe_count, .multiframe_boundary);
  link_rx_model rx_u (.clock, .want_sync, .want_stamp, .sync_input_pin, .timestamp_input_pin);

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: read %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_out(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: output %h want %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One 24-bit frame; sclk phases of 5 cycles keep clear of the synchroniser
  task automatic spi(input logic [23:0] f, output logic [7:0] rd);
    rd = 8'h00;
    spi_cs_n = 1'b0;
    cyc(5);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = f[i];
      cyc(5);
      if (i < 8) rd = {rd[6:0], spi_sdo_o};
      chk_out(12'(spi_sdo_oe), 12'(f[23] && i < 8));
      spi_sclk = 1'b1;
      cyc(5);
      spi_sclk = 1'b0;
    end
    cyc(5);
    spi_cs_n = 1'b1;
    cyc(5);
  endtask

  task automatic rd_all();
    for (int i = 0; i < 5; i++) begin
      spi({1'b1, 15'(i + 'h202), 8'h00}, rdv);
      chk_rd(rdv, (i < 4) ? mdl[i] : 8'h00);
    end
  endtask

  task automatic do_reset(input int n);
    sys_rst = 1'b1;
    link_enable = 1'b0;
    cyc(n);
    sys_rst = 1'b0;
    mdl = '{8'h1F, 8'h01, 8'h03, 8'h00};
  endtask

  // Cuts a hung run short
  initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    $display("unexpected at %0t: run too long", $time);
    tally_and_finish();
  end

  initial begin
    {spi_sclk, spi_sdi, frame_tick, want_sync, want_stamp} = '0;
    {timestamp_receiver_enable, mode_is_64b66b, mode_e, mode_f} = '0;
    spi_cs_n = 1'b1;
    void'($urandom(92917));
    do_reset(20);
    rd_all();
    for (int i = 0; i < 10; i++) begin
      link_enable = 1'b0;
      cyc(2);
      chk_out(12'({link_reset, serializer_clock_en, scramble_active, serial_hold_low,
                   serial_hold_high}), 12'h010);
      chk_out({4'h0, lane_power_a | lane_power_b}, 12'h000);
      chk_out(multiframe_count, 12'h000);
      // Bench keeps the stored length to at most eight frames per multiframe
      mdl[0] = 8'($urandom % 8);
      mdl[1] = 8'($urandom);
      mdl[2] = 8'($urandom);
      mdl[3] = {3'($urandom), codes[i]};
      for (int j = 0; j < 4; j++) spi({1'b0, 15'(j + 'h202), mdl[j]}, rdv);
      rd_all();
      mode_is_64b66b = 1'($urandom);
      mode_e = 3'(1 + $urandom % 7);
      mode_f = 5'($urandom);
      {timestamp_receiver_enable, want_sync, want_stamp} = 3'($urandom);
      link_enable = 1'b1;
      cyc(6);
      kk = !mode_is_64b66b ? mdl[0] : (mode_f == 0) ? 255 : 256 * mode_e / mode_f - 1;
      pin = mdl[2][3:2] == 2'h0 ? !want_sync
          : (mdl[2][3:2] == 2'h1 && timestamp_receiver_enable) ? !want_stamp : 1'b1;
      chk_out(12'(lane_power_a), mdl[2][4] ? 12'h0F0 : 12'h00F);
      chk_out(12'(lane_power_b), mdl[2][4] ? 12'h0F0 : 12'h00F);
      chk_out(12'({link_reset, serializer_clock_en}), 12'h001);
      chk_out(12'(sample_twos_complement), 12'(mdl[2][1]));
      chk_out(12'(scramble_active), 12'(mode_is_64b66b | mdl[2][0]));
      chk_out(12'(test_pattern_select), 12'(mdl[3][4:0]));
      chk_out(12'({serial_hold_high, serial_hold_low}),
              12'({mdl[3][4:0] == 5'h0B, mdl[3][4:0] == 5'h0A}));
      chk_out(12'(sync_request_n), 12'(mdl[1][0] & pin));
      chk_out(frames_per_multiframe_minus_one, 12'(kk));
      cnt = 0;
      repeat (1 + $urandom % 40) begin
        frame_tick = 1'b1;
        cyc(1);
        chk_out(12'(multiframe_boundary), 12'(cnt >= kk));
        frame_tick = 1'b0;
        cyc(1);
        cnt = (cnt >= kk) ? 0 : cnt + 1;
      end
      chk_out(multiframe_count, 12'(cnt));
    end
    do_reset(3);
    rd_all();
    tally_and_finish();
  end
endmodule

bind serial_link_config_regs link_cfg_monitor mon_u (.clock, .sys_rst, .link_enable,
  .mode_is_64b66b, .mode_e, .mode_f, .link_reset, .serializer_clock_en, .lane_power_a,
  .lane_power_b, .scramble_active, .test_pattern_select, .serial_hold_low, .serial_hold_high,
  .frames_per_multiframe_minus_one, .multiframe_count, .multiframe_boundary);

// ### logic/link_cfg_consts.svh
`ifndef LINK_CFG_CONSTS_SVH
`define LINK_CFG_CONSTS_SVH
// Behaviour
// - The multiframe length register holds frames per multiframe minus one and resets to 31.
// - In 64b/66b modes the stored length is ignored and frames per multiframe is 256*E/F.
// - Writing 0 to bit 0 of the sync request register asserts a sync request; reset is 1.
// - The software request always acts, but a low selected pin holds the request unless source 2.
// - Lane map bit 0 powers lanes 0 to 3 of both links and powers down the rest.
// - Lane map bit 1 powers lanes 4 to 7 of both links and powers down lanes 0 to 3.
// - Sync source bits 3:2 pick the sync pin (0), the timestamp pin with receiver on (1), or none (2).
// - Bit 1 picks offset binary (0) or two's complement (1, reset) samples.
// - Bit 0 enables 8b/10b scrambling, resets to 1, and only matters in 8b/10b modes.
// - In 64b/66b modes output data is always scrambled.
// - The five-bit test field picks normal data, PRBS, ramp, transport, or held-low/high outputs.
// - With the link disabled the link logic and multiframe counter are held in reset and lanes off.

// Register addresses on the serial port
`define ADDR_MULTIFRAME_LENGTH  15'h0202
`define ADDR_MANUAL_SYNC_REQ    15'h0203
`define ADDR_LINK_CONTROL       15'h0204
`define ADDR_LINK_TEST_CONTROL  15'h0205

// Reset values
`define RST_MULTIFRAME_LENGTH   8'h1F
`define RST_MANUAL_SYNC_REQ     8'h01
`define RST_LINK_CONTROL        8'h03
`define RST_LINK_TEST_CONTROL   8'h00

// Field positions
`define SOFT_SYNC_BIT           0
`define SCRAMBLER_BIT           0
`define SAMPLE_FORMAT_BIT       1
`define SYNC_SEL_LSB            2
`define SYNC_SEL_MSB            3
`define LANE_MAP_BIT            4
`define TEST_SEL_MSB            4

// Lane groups and 64b/66b multiframe numerator
`define LOWER_LANES             8'h0F
`define UPPER_LANES             8'hF0
`define EMB_FRAME_SCALE         12'h100

// Serial frame layout: 1 direction bit, 15 address bits, 8 data bits
`define SPI_HDR_LAST            5'h0F
`define SPI_FRAME_LAST          5'h17
`endif

// ### logic/link_cfg_pkg.sv
package link_cfg_pkg;
  typedef enum logic [1:0] {
    SYNC_FROM_PIN    = 2'h0,
    SYNC_FROM_TSTAMP = 2'h1,
    SYNC_FROM_SOFT   = 2'h2
  } sync_src_t;

  typedef enum logic [4:0] {
    PAT_NORMAL    = 5'h00,
    PAT_PRBS7     = 5'h01,
    PAT_PRBS15    = 5'h02,
    PAT_PRBS23    = 5'h03,
    PAT_RAMP      = 5'h04,
    PAT_TRANSPORT = 5'h05,
    PAT_HOLD_LOW  = 5'h0A,
    PAT_HOLD_HIGH = 5'h0B,
    PAT_PRBS9     = 5'h0D,
    PAT_PRBS31    = 5'h0E
  } test_pat_t;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_HDR  = 3'b010,
    SPI_DATA = 3'b100
  } spi_state_t;
endpackage

// ### logic/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
  logic [14:0] addr;
  logic        wr_stb;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  modport master (output addr, output wr_stb, output wdata, input rdata);
  modport slave  (input addr, input wr_stb, input wdata, output rdata);
endinterface

// ### logic/serial_link_config_regs.sv
`timescale 1ns/1ps
`include "link_cfg_consts.svh"
module serial_link_config_regs import link_cfg_pkg::*; (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  sys_rst,
  // Serial register port
  input  wire logic  spi_sclk,
  input  wire logic  spi_cs_n,
  input  wire logic  spi_sdi,
  output logic       spi_sdo_o,
  output logic       spi_sdo_oe,
  // Settings held by neighbouring registers
  input  wire logic  link_enable,
  input  wire logic  timestamp_receiver_enable,
  input  wire logic  mode_is_64b66b,
  input  wire logic  [2:0] mode_e,
  input  wire logic  [4:0] mode_f,
  // Sync pins, active low
  input  wire logic  sync_input_pin,
  input  wire logic  timestamp_input_pin,
  // Frame timing from the framer
  input  wire logic  frame_tick,
  // Link controls
  output logic       link_reset,
  output logic       serializer_clock_en,
  output logic [7:0] lane_power_a,
  output logic [7:0] lane_power_b,
  output logic       sync_request_n,
  output logic       sample_twos_complement,
  output logic       scramble_active,
  output logic [4:0] test_pattern_select,
  output logic       serial_hold_low,
  output logic       serial_hold_high,
  output logic [11:0] frames_per_multiframe_minus_one,
  output logic [11:0] multiframe_count,
  output logic       multiframe_boundary
);
  reg_access_if bus ();

  logic [7:0]  mfl_q;
  logic [7:0]  sync_reg_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  test_q;
  logic [1:0]  sync_pin_s_q;
  logic [1:0]  tstamp_pin_s_q;
  logic        pin_sync_n;
  logic [11:0] k_emb;
  logic [11:0] k_m1_d;
  logic [11:0] k_m1_q;
  logic [11:0] mf_cnt_q;
  logic        mf_bnd_q;
  logic [4:0]  pat_d;

  function automatic logic hit(input logic [14:0] a, input logic [14:0] off);
    hit = bus.wr_stb && (a == off);
  endfunction

  spi_reg_port u_port (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .spi_sclk   (spi_sclk),
    .spi_cs_n   (spi_cs_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo_o  (spi_sdo_o),
    .spi_sdo_oe (spi_sdo_oe),
    .bus        (bus.master)
  );

  // Register storage, full byte kept so reserved bits read back
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mfl_q      <= `RST_MULTIFRAME_LENGTH;
      sync_reg_q <= `RST_MANUAL_SYNC_REQ;
      ctrl_q     <= `RST_LINK_CONTROL;
      test_q     <= `RST_LINK_TEST_CONTROL;
    end else begin
      // No interlock on link state: software owns the ordering
      if (hit(bus.addr, `ADDR_MULTIFRAME_LENGTH)) mfl_q <= bus.wdata;
      if (hit(bus.addr, `ADDR_MANUAL_SYNC_REQ)) sync_reg_q <= bus.wdata;
      if (hit(bus.addr, `ADDR_LINK_CONTROL)) ctrl_q <= bus.wdata;
      if (hit(bus.addr, `ADDR_LINK_TEST_CONTROL)) test_q <= bus.wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (bus.addr)
      `ADDR_MULTIFRAME_LENGTH: bus.rdata = mfl_q;
      `ADDR_MANUAL_SYNC_REQ:   bus.rdata = sync_reg_q;
      `ADDR_LINK_CONTROL:      bus.rdata = ctrl_q;
      `ADDR_LINK_TEST_CONTROL: bus.rdata = test_q;
      default:                 bus.rdata = 8'h00;
    endcase
  end

  // Sync pins are asynchronous to the register clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_pin_s_q   <= 2'h3;
      tstamp_pin_s_q <= 2'h3;
    end else begin
      sync_pin_s_q   <= {sync_pin_s_q[0], sync_input_pin};
      tstamp_pin_s_q <= {tstamp_pin_s_q[0], timestamp_input_pin};
    end
  end

  // Pin source select; reserved code 3 behaves like software only
  always_comb begin
    case (ctrl_q[`SYNC_SEL_MSB:`SYNC_SEL_LSB])
      SYNC_FROM_PIN:    pin_sync_n = sync_pin_s_q[1];
      SYNC_FROM_TSTAMP: pin_sync_n = tstamp_pin_s_q[1] | ~timestamp_receiver_enable;
      SYNC_FROM_SOFT:   pin_sync_n = 1'b1;
      default:          pin_sync_n = 1'b1;
    endcase
  end

  // Either source can pull the request low; a stuck pin wins until source 2
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_request_n <= 1'b1;
    end else begin
      sync_request_n <= sync_reg_q[`SOFT_SYNC_BIT] & pin_sync_n;
    end
  end

  // Effective multiframe length; zero F guarded to avoid a divide fault
  assign k_emb = (mode_f == 5'h00) ? `EMB_FRAME_SCALE
                                   : (12'({mode_e, 8'h00}) / 12'(mode_f));
  assign k_m1_d = mode_is_64b66b ? (k_emb - 12'h001) : {4'h0, mfl_q};

  // Test pattern decode; unlisted codes pass through for the framer
  always_comb begin
    pat_d = test_q[`TEST_SEL_MSB:0];
  end

  // Link reset and serializer clock gate follow the enable one edge late
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_reset          <= 1'b1;
      serializer_clock_en <= 1'b0;
    end else begin
      link_reset          <= ~link_enable;
      serializer_clock_en <= link_enable;
    end
  end

  // Lane power; the upper map is not checked against the lane count of the mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lane_power_a <= 8'h00;
      lane_power_b <= 8'h00;
    end else if (!link_enable) begin
      lane_power_a <= 8'h00;
      lane_power_b <= 8'h00;
    end else if (ctrl_q[`LANE_MAP_BIT]) begin
      lane_power_a <= `UPPER_LANES;
      lane_power_b <= `UPPER_LANES;
    end else begin
      lane_power_a <= `LOWER_LANES;
      lane_power_b <= `LOWER_LANES;
    end
  end

  // Sample format follows the register even while the link is off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sample_twos_complement <= 1'b1;
    end else begin
      sample_twos_complement <= ctrl_q[`SAMPLE_FORMAT_BIT];
    end
  end

  // Scrambling; 64b/66b modes override the register bit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scramble_active <= 1'b0;
    end else begin
      scramble_active <= link_enable & (mode_is_64b66b | ctrl_q[`SCRAMBLER_BIT]);
    end
  end

  // Test pattern code and the two held-level outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      test_pattern_select <= 5'h00;
      serial_hold_low     <= 1'b0;
      serial_hold_high    <= 1'b0;
    end else begin
      test_pattern_select <= pat_d;
      serial_hold_low     <= link_enable & (pat_d == PAT_HOLD_LOW);
      serial_hold_high    <= link_enable & (pat_d == PAT_HOLD_HIGH);
    end
  end

  // Registered length so the counter compares against a settled value
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      k_m1_q <= {4'h0, `RST_MULTIFRAME_LENGTH};
    end else begin
      k_m1_q <= k_m1_d;
    end
  end

  // Multiframe counter, cleared and frozen while the link is off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mf_cnt_q <= 12'h000;
      mf_bnd_q <= 1'b0;
    end else if (!link_enable) begin
      mf_cnt_q <= 12'h000;
      mf_bnd_q <= 1'b0;
    end else begin
      mf_bnd_q <= 1'b0;
      if (frame_tick) begin
        if (mf_cnt_q >= k_m1_q) begin
          mf_cnt_q <= 12'h000;
          mf_bnd_q <= 1'b1;
        end else begin
          mf_cnt_q <= mf_cnt_q + 12'h001;
        end
      end
    end
  end

  assign frames_per_multiframe_minus_one = k_m1_q;
  assign multiframe_count                = mf_cnt_q;
  assign multiframe_boundary             = mf_bnd_q;
endmodule

// ### logic/spi_reg_port.sv
`timescale 1ns/1ps
`include "link_cfg_consts.svh"
module spi_reg_port import link_cfg_pkg::*; (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   sys_rst,
  // Serial port pins
  input  wire logic   spi_sclk,
  input  wire logic   spi_cs_n,
  input  wire logic   spi_sdi,
  output logic        spi_sdo_o,
  output logic        spi_sdo_oe,
  // Register access
  reg_access_if.master bus
);
  logic [2:0]  sclk_s_q;
  logic [1:0]  cs_n_s_q;
  logic [1:0]  sdi_s_q;
  spi_state_t  state_q;
  logic [4:0]  cnt_q;
  logic [15:0] shift_q;
  logic        read_q;
  logic        load_q;
  logic        pend_q;
  logic [7:0]  sdo_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sel;

  // Pins come from the host's clock; the edge detector reads stages 2 and 3 only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_s_q <= 3'h0;
      cs_n_s_q <= 2'h3;
      sdi_s_q  <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
      cs_n_s_q <= {cs_n_s_q[0], spi_cs_n};
      sdi_s_q  <= {sdi_s_q[0], spi_sdi};
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  assign sel       = ~cs_n_s_q[1];

  // Frame sequencer; deselect aborts any partial frame without a write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q    <= SPI_IDLE;
      cnt_q      <= 5'h00;
      shift_q    <= 16'h0000;
      read_q     <= 1'b0;
      load_q     <= 1'b0;
      bus.addr   <= 15'h0000;
      bus.wr_stb <= 1'b0;
      bus.wdata  <= 8'h00;
    end else begin
      bus.wr_stb <= 1'b0;
      load_q     <= 1'b0;
      if (!sel) begin
        state_q <= SPI_IDLE;
      end else begin
        case (state_q)
          SPI_IDLE: begin
            state_q <= SPI_HDR;
            cnt_q   <= 5'h00;
          end
          SPI_HDR: begin
            if (sclk_rise) begin
              shift_q <= {shift_q[14:0], sdi_s_q[1]};
              cnt_q   <= cnt_q + 5'h01;
              if (cnt_q == `SPI_HDR_LAST) begin
                read_q   <= shift_q[14];
                bus.addr <= {shift_q[13:0], sdi_s_q[1]};
                load_q   <= shift_q[14];
                state_q  <= SPI_DATA;
              end
            end
          end
          SPI_DATA: begin
            if (sclk_rise) begin
              shift_q <= {shift_q[14:0], sdi_s_q[1]};
              cnt_q   <= cnt_q + 5'h01;
              if (cnt_q == `SPI_FRAME_LAST) begin
                bus.wr_stb <= ~read_q;
                bus.wdata  <= {shift_q[6:0], sdi_s_q[1]};
                state_q    <= SPI_IDLE;
              end
            end
          end
          default: state_q <= SPI_IDLE;
        endcase
      end
    end
  end

  // Read data loads a cycle after the address settles, shifts on falling edges
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sdo_q  <= 8'h00;
      pend_q <= 1'b0;
    end else if (load_q) begin
      sdo_q  <= bus.rdata;
      pend_q <= 1'b0;
    end else if (state_q == SPI_DATA && sclk_rise) begin
      pend_q <= 1'b1;
    end else if (pend_q && sclk_fall) begin
      sdo_q  <= {sdo_q[6:0], 1'b0};
      pend_q <= 1'b0;
    end
  end

  assign spi_sdo_o  = sdo_q[7];
  assign spi_sdo_oe = sel & read_q & (state_q == SPI_DATA);
endmodule
